// ### rtl/fpe_pkg.sv
// Constants for the flash program/erase control block.
// Assumes a 16-bit peripheral bus with full 24-bit byte addresses.
package fpe_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [23:0] ADDR_INFO_DATA = 24'hff_f942;
  localparam logic [23:0] ADDR_LOW_WE = 24'hff_f944;
  localparam logic [23:0] ADDR_HIGH_WE = 24'hff_f946;
  localparam logic [23:0] ADDR_DATA_WE = 24'hff_f744;
  localparam logic [23:0] ADDR_CTRL = 24'hff_f94c;
  localparam logic [23:0] ADDR_STAT = 24'hff_f94e;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ==========================================================
  // Control bits
  localparam int CTL_HALF_READ = 0;
  localparam int CTL_CPU_BLOCK = 1;
  localparam int CTL_SKIP_VERIFY = 3;
  localparam int CTL_IRQ_EN = 4;
  localparam int CTL_PROGRAM = 5;
  localparam int CTL_PAGE_WIPE = 6;
  localparam int CTL_BLOCK_WIPE = 7;
  localparam logic [7:0] CTL_WMASK = 8'hfb;
  // ==========================================================
  // Status bits
  localparam int ST_WIPE_FAULT = 0;
  localparam int ST_PROG_FAULT = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_OCCUPIED = 3;
  localparam int ST_OVERRUN = 4;
  // ==========================================================
  // Address map of the protected sections
  localparam int PROG_SEC_LSB = 13;
  localparam int DATA_SEC_LSB = 9;
  localparam int PAGE_LSB = 10;
  localparam int HALF_TAG_LSB = 17;
  localparam int DATA_TAG_LSB = 13;
  localparam logic [6:0] LOW_HALF_TAG = 7'h00;
  localparam logic [6:0] HIGH_HALF_TAG = 7'h01;
  localparam logic [10:0] DATA_FLASH_TAG = 11'h068;
  // ==========================================================
  // Array operations and sequencer states
  typedef enum logic [2:0] {
    FPE_OP_READ = 3'h0,
    FPE_OP_PROGRAM = 3'h1,
    FPE_OP_PAGE_WIPE = 3'h2,
    FPE_OP_BLOCK_WIPE = 3'h3
  } fpe_op_e;
  typedef enum logic [2:0] {
    FPE_ST_IDLE = 3'b001,
    FPE_ST_LAUNCH = 3'b010,
    FPE_ST_WAIT = 3'b100
  } fpe_state_e;
endpackage

// ### rtl/fpe_flash_ctrl.sv
// Flash program/erase control: registers, section protection, sequencer.
// Assumes the array answers each start pulse with one arr_done pulse.
`timescale 1ns/10ps
module fpe_flash_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [23:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Flash write requests
  input wire logic fl_wr_req,
  input wire logic fl_wr_debug,
  input wire logic fl_wr_info,
  input wire logic [23:0] fl_wr_addr,
  input wire logic [15:0] fl_wr_data,
  input wire logic [7:0] info_location,
  input wire logic info_rd_req,
  output logic cpu_stall,
  output logic irq_buffer_ready,
  // Flash array
  output logic arr_start,
  output logic [2:0] arr_op,
  output logic [23:0] arr_addr,
  output logic [15:0] arr_wdata,
  output logic arr_info,
  output logic arr_verify,
  output logic arr_low_power,
  input wire logic arr_done,
  input wire logic arr_fail,
  input wire logic [15:0] arr_rdata
);
  // ==========================================================
  // Register state
  logic [15:0] info_word_reg, info_word_next;
  logic [15:0] low_en_reg, low_en_next;
  logic [15:0] high_en_reg, high_en_next;
  logic [15:0] data_en_reg, data_en_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic wipe_fault_reg, wipe_fault_next;
  logic prog_fault_reg, prog_fault_next;
  logic overrun_reg, overrun_next;
  logic [15:0] rdata_reg, rdata_next;
  // Sequencer state
  fpe_pkg::fpe_state_e state_reg, state_next;
  logic occupied_reg, occupied_next;
  logic active_reg, active_next;
  logic irq_reg, irq_next;
  logic [2:0] op_reg, op_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic info_reg, info_next;
  // Decode
  logic sel_info, sel_low, sel_high, sel_data, sel_ctrl, sel_stat;
  logic sec_ok, mode_ok, req_valid, busy_any, accept, rd_accept, done_ok;
  logic [2:0] req_op;
  logic [23:0] req_addr;
  logic [15:0] stat_word;

  assign sel_info = reg_addr == fpe_pkg::ADDR_INFO_DATA;
  assign sel_low = reg_addr == fpe_pkg::ADDR_LOW_WE;
  assign sel_high = reg_addr == fpe_pkg::ADDR_HIGH_WE;
  assign sel_data = reg_addr == fpe_pkg::ADDR_DATA_WE;
  assign sel_ctrl = reg_addr == fpe_pkg::ADDR_CTRL;
  assign sel_stat = reg_addr == fpe_pkg::ADDR_STAT;
  assign busy_any = active_reg | occupied_reg;
  assign stat_word = {11'h000, overrun_reg, occupied_reg, active_reg,
                      prog_fault_reg, wipe_fault_reg};

  // ==========================================================
  // Section protection and mode selection
  always_comb begin
    sec_ok = 1'b0;
    if (fl_wr_info) begin
      sec_ok = 1'b1;
    end else if (fl_wr_addr[23:fpe_pkg::HALF_TAG_LSB] ==
                 fpe_pkg::LOW_HALF_TAG) begin
      sec_ok = low_en_reg[fl_wr_addr[fpe_pkg::PROG_SEC_LSB +: 4]];
    end else if (fl_wr_addr[23:fpe_pkg::HALF_TAG_LSB] ==
                 fpe_pkg::HIGH_HALF_TAG) begin
      sec_ok = high_en_reg[fl_wr_addr[fpe_pkg::PROG_SEC_LSB +: 4]];
    end else if (fl_wr_addr[23:fpe_pkg::DATA_TAG_LSB] ==
                 fpe_pkg::DATA_FLASH_TAG) begin
      sec_ok = data_en_reg[fl_wr_addr[fpe_pkg::DATA_SEC_LSB +: 4]];
    end
  end

  always_comb begin
    mode_ok = 1'b1;
    req_op = fpe_pkg::FPE_OP_PROGRAM;
    req_addr = fl_wr_info ? {16'h0000, info_location[7:1], 1'b0} : fl_wr_addr;
    // Priority only matters if software breaks the one-mode
    if (ctrl_reg[fpe_pkg::CTL_BLOCK_WIPE]) begin
      req_op = fpe_pkg::FPE_OP_BLOCK_WIPE;
    end else if (ctrl_reg[fpe_pkg::CTL_PAGE_WIPE]) begin
      req_op = fpe_pkg::FPE_OP_PAGE_WIPE;
      req_addr[fpe_pkg::PAGE_LSB-1:0] = '0;
      mode_ok = ~fl_wr_info;
    end else begin
      mode_ok = ctrl_reg[fpe_pkg::CTL_PROGRAM];
    end
  end

  // CPU writes are refused while the debug tool owns the interface
  assign req_valid = fl_wr_req & sec_ok & mode_ok &
                     (fl_wr_debug | ~ctrl_reg[fpe_pkg::CTL_CPU_BLOCK]);
  assign cpu_stall = (fl_wr_req | info_rd_req) & ~fl_wr_debug & busy_any;
  assign accept = req_valid & ~busy_any;
  assign rd_accept = info_rd_req & ~fl_wr_req & ~busy_any;
  assign done_ok = (state_reg == fpe_pkg::FPE_ST_WAIT) & arr_done;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    occupied_next = occupied_reg;
    active_next = active_reg;
    irq_next = 1'b0;
    op_next = op_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    info_next = info_reg;
    case (state_reg)
      fpe_pkg::FPE_ST_IDLE: begin
        if (accept) begin
          occupied_next = 1'b1;
          op_next = req_op;
          addr_next = req_addr;
          wdata_next = fl_wr_info ? info_word_reg : fl_wr_data;
          info_next = fl_wr_info;
          state_next = fpe_pkg::FPE_ST_LAUNCH;
        end else if (rd_accept) begin
          active_next = 1'b1;
          op_next = fpe_pkg::FPE_OP_READ;
          addr_next = {16'h0000, info_location[7:1], 1'b0};
          info_next = 1'b1;
          state_next = fpe_pkg::FPE_ST_LAUNCH;
        end
      end
      fpe_pkg::FPE_ST_LAUNCH: begin
        // Buffer hands its word to the array; busy covers the operation
        occupied_next = 1'b0;
        active_next = 1'b1;
        irq_next = occupied_reg & ctrl_reg[fpe_pkg::CTL_IRQ_EN];
        state_next = fpe_pkg::FPE_ST_WAIT;
      end
      fpe_pkg::FPE_ST_WAIT: begin
        if (arr_done) begin
          active_next = 1'b0;
          state_next = fpe_pkg::FPE_ST_IDLE;
        end
      end
      default: begin
        state_next = fpe_pkg::FPE_ST_IDLE;
        occupied_next = 1'b0;
        active_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fpe_pkg::FPE_ST_IDLE;
      occupied_reg <= 1'b0;
      active_reg <= 1'b0;
      irq_reg <= 1'b0;
      op_reg <= fpe_pkg::FPE_OP_READ;
      addr_reg <= 24'h00_0000;
      wdata_reg <= fpe_pkg::RST_WORD;
      info_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      occupied_reg <= occupied_next;
      active_reg <= active_next;
      irq_reg <= irq_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      info_reg <= info_next;
    end
  end

  assign arr_start = state_reg == fpe_pkg::FPE_ST_LAUNCH;
  assign arr_op = op_reg;
  assign arr_addr = addr_reg;
  assign arr_wdata = wdata_reg;
  assign arr_info = info_reg;
  assign arr_verify = ~ctrl_reg[fpe_pkg::CTL_SKIP_VERIFY];
  // Array gates its sensing to the high clock phase while this is set
  assign arr_low_power = ctrl_reg[fpe_pkg::CTL_HALF_READ];
  assign irq_buffer_ready = irq_reg;

  // ==========================================================
  // Register file
  always_comb begin
    info_word_next = info_word_reg;
    low_en_next = low_en_reg;
    high_en_next = high_en_reg;
    data_en_next = data_en_reg;
    ctrl_next = ctrl_reg;
    wipe_fault_next = wipe_fault_reg;
    prog_fault_next = prog_fault_reg;
    overrun_next = overrun_reg;
    rdata_next = rdata_reg;
    if (reg_wr) begin
      if (sel_info) info_word_next = reg_wdata;
      if (sel_low) low_en_next = reg_wdata;
      if (sel_high) high_en_next = reg_wdata;
      if (sel_data) data_en_next = reg_wdata;
      if (sel_ctrl) ctrl_next = reg_wdata[7:0] & fpe_pkg::CTL_WMASK;
      if (sel_stat) begin
        // Write one clears, write zero
        if (reg_wdata[fpe_pkg::ST_WIPE_FAULT]) wipe_fault_next = 1'b0;
        if (reg_wdata[fpe_pkg::ST_PROG_FAULT]) prog_fault_next = 1'b0;
        if (reg_wdata[fpe_pkg::ST_OVERRUN]) overrun_next = 1'b0;
      end
    end
    // Hardware set follows the clear so it wins
    if (done_ok && op_reg == fpe_pkg::FPE_OP_READ) begin
      info_word_next = arr_rdata;
    end
    if (done_ok && arr_fail) begin
      if (op_reg == fpe_pkg::FPE_OP_PROGRAM) prog_fault_next = 1'b1;
      if (op_reg == fpe_pkg::FPE_OP_PAGE_WIPE ||
          op_reg == fpe_pkg::FPE_OP_BLOCK_WIPE) wipe_fault_next = 1'b1;
    end
    if (req_valid && fl_wr_debug && busy_any) overrun_next = 1'b1;
    if (reg_rd) begin
      rdata_next = 16'h0000;
      if (sel_info) rdata_next = info_word_reg;
      if (sel_low) rdata_next = low_en_reg;
      if (sel_high) rdata_next = high_en_reg;
      if (sel_data) rdata_next = data_en_reg;
      if (sel_ctrl) rdata_next = {8'h00, ctrl_reg};
      if (sel_stat) rdata_next = stat_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      info_word_reg <= fpe_pkg::RST_WORD;
      low_en_reg <= fpe_pkg::RST_WORD;
      high_en_reg <= fpe_pkg::RST_WORD;
      data_en_reg <= fpe_pkg::RST_WORD;
      ctrl_reg <= fpe_pkg::RST_BYTE;
      wipe_fault_reg <= 1'b0;
      prog_fault_reg <= 1'b0;
      overrun_reg <= 1'b0;
      rdata_reg <= fpe_pkg::RST_WORD;
    end else begin
      info_word_reg <= info_word_next;
      low_en_reg <= low_en_next;
      high_en_reg <= high_en_next;
      data_en_reg <= data_en_next;
      ctrl_reg <= ctrl_next;
      wipe_fault_reg <= wipe_fault_next;
      prog_fault_reg <= prog_fault_next;
      overrun_reg <= overrun_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_busy_after_accept;
    accept |=> occupied_reg ##1 active_reg;
  endproperty
  a_busy_after_accept: assert property (p_busy_after_accept)
    else $error("busy not raised after accepted request");

  property p_no_accept_busy;
    busy_any |=> !arr_start;
  endproperty
  a_no_accept_busy: assert property (p_no_accept_busy)
    else $error("request accepted while busy");

  property p_stall;
    (fl_wr_req && !fl_wr_debug && active_reg) |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall)
    else $error("cpu not stalled while busy");

  property p_cpu_block;
    (fl_wr_req && !fl_wr_debug && ctrl_reg[fpe_pkg::CTL_CPU_BLOCK])
      |-> !req_valid;
  endproperty
  a_cpu_block: assert property (p_cpu_block)
    else $error("cpu write passed while blocked");

  property p_page_info;
    (fl_wr_req && fl_wr_info && ctrl_reg[fpe_pkg::CTL_PAGE_WIPE] &&
     !ctrl_reg[fpe_pkg::CTL_BLOCK_WIPE]) |-> !req_valid;
  endproperty
  a_page_info: assert property (p_page_info)
    else $error("page wipe of info block accepted");

  property p_irq;
    $fell(occupied_reg) |-> irq_reg == $past(ctrl_reg[fpe_pkg::CTL_IRQ_EN]);
  endproperty
  a_irq: assert property (p_irq)
    else $error("buffer ready interrupt wrong");

  property p_prog_fault;
    (done_ok && arr_fail && op_reg == fpe_pkg::FPE_OP_PROGRAM)
      |=> prog_fault_reg;
  endproperty
  a_prog_fault: assert property (p_prog_fault)
    else $error("program fault not set");

  property p_w1c_keep;
    (reg_wr && sel_stat && !reg_wdata[fpe_pkg::ST_WIPE_FAULT] &&
     wipe_fault_reg) |=> wipe_fault_reg;
  endproperty
  a_w1c_keep: assert property (p_w1c_keep)
    else $error("erase fault lost on write of zero");

  property p_busy_clear;
    done_ok |=> !active_reg && state_reg == fpe_pkg::FPE_ST_IDLE;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy not cleared after done");

  property p_verify;
    (reg_wr && sel_ctrl) |=>
      arr_verify == !$past(reg_wdata[fpe_pkg::CTL_SKIP_VERIFY]);
  endproperty
  a_verify: assert property (p_verify)
    else $error("verify request wrong");

  c_program: cover property (accept && req_op == fpe_pkg::FPE_OP_PROGRAM);
  c_wipe_fail: cover property (done_ok && arr_fail &&
                               op_reg != fpe_pkg::FPE_OP_PROGRAM);
  c_info_read: cover property (done_ok && op_reg == fpe_pkg::FPE_OP_READ);
  c_stall: cover property (cpu_stall ##1 !cpu_stall);
endmodule

// ### tb/fpe_array_model.sv
// Behavioural flash array that answers the control block's start pulses.
// Assumes one operation at a time; the bench sets its length and outcome.
`timescale 1ns/10ps
module fpe_array_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Array port
  input wire logic arr_start,
  input wire logic [2:0] arr_op,
  input wire logic [23:0] arr_addr,
  input wire logic [15:0] arr_wdata,
  input wire logic arr_info,
  output logic arr_done,
  output logic arr_fail,
  output logic [15:0] arr_rdata,
  // Bench control
  input wire logic [3:0] op_cycles,
  input wire logic fail_next
);
  // Info block words, one per word address; erased words read all ones
  logic [15:0] info_mem [128];
  logic [127:0] info_set;
  logic [2:0] op;
  logic [6:0] a;
  logic [15:0] d;
  logic inf, f;
  logic [3:0] cnt;
  // =====================================================
  // Operation timing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      info_set <= '0;
      op <= 3'h0;
      a <= 7'h00;
      d <= 16'h0000;
      inf <= 1'b0;
      f <= 1'b0;
      arr_done <= 1'b0;
      arr_fail <= 1'b0;
      arr_rdata <= 16'h0000;
    end else begin
      // Outside the done cycle arr_fail and arr_rdata keep moving; arr_done stays low
      arr_done <= 1'b0;
      arr_fail <= ~arr_fail;
      arr_rdata <= ~arr_rdata;
      if (arr_start) begin
        cnt <= op_cycles;
        op <= arr_op;
        a <= arr_addr[7:1];
        d <= arr_wdata;
        inf <= arr_info;
        f <= fail_next;
      end else if (cnt > 4'h1) begin
        cnt <= cnt - 4'h1;
      end else if (cnt == 4'h1) begin
        cnt <= 4'h0;
        arr_done <= 1'b1;
        arr_fail <= f;
        if (op == 3'h0) begin
          arr_rdata <= info_set[a] ? info_mem[a] : 16'hffff;
        end
        if (op == 3'h1 && inf) begin
          info_mem[a] <= d;
          info_set[a] <= 1'b1;
        end
        if (op == 3'h3 && inf) begin
          info_set <= '0;
        end
      end
    end
  end
endmodule

// ### tb/flash_program_erase_control_test.sv
// Self-checking bench for the flash program/erase control block.
// Assumes the array model of fpe_array_model.sv; one clock domain.
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("BAD %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module flash_program_erase_control_test;
  logic ref_clk, rst_n, reg_wr, reg_rd, fl_wr_req, fl_wr_debug;
  logic fl_wr_info, info_rd_req, cpu_stall, irq_buffer_ready;
  logic arr_start, arr_info, arr_verify, arr_low_power, arr_done;
  logic arr_fail, fail_next;
  logic [23:0] reg_addr, fl_wr_addr, arr_addr;
  logic [15:0] reg_wdata, reg_rdata, fl_wr_data, arr_wdata, arr_rdata;
  logic [15:0] ctl, st, rv;
  logic [7:0] info_location;
  logic [2:0] arr_op;
  logic [3:0] op_cycles;
  logic [23:0] ra [5];
  int n_errors, checks_done, n, sz, a;

  fpe_flash_ctrl dut (.*);
  fpe_array_model u_array (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // =====================================================
  // Bus and request tasks
  task automatic wr(input logic [23:0] ad, input logic [15:0] dt);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [23:0] ad, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  // Only one mode bit is set, never while busy
  task automatic wctl(input logic [15:0] v);
    wr(fpe_pkg::ADDR_CTRL, v);
    ctl = v;
  endtask
  task automatic req(input logic [23:0] ad, input logic [15:0] dt,
                     input logic inf, input logic dbg, input logic tk,
                     input logic [2:0] eop, input logic [23:0] ea);
    @(posedge ref_clk);
    fl_wr_addr <= ad;
    fl_wr_data <= dt;
    fl_wr_info <= inf;
    fl_wr_debug <= dbg;
    fl_wr_req <= 1'b1;
    @(posedge ref_clk);
    fl_wr_req <= 1'b0;
    #1 `CHK(arr_start, tk)
    if (tk) begin
      `CHK(arr_op, eop)
      `CHK(arr_info, inf)
      if (eop == 3'h1) `CHK(arr_wdata, dt)
      if (eop != 3'h3) `CHK(arr_addr, ea)
      @(posedge ref_clk);
      #1 `CHK(irq_buffer_ready, ctl[fpe_pkg::CTL_IRQ_EN])
    end
  endtask
  task automatic fin(input logic [2:0] op);
    for (int k = 0; k < 40 && !arr_done; k++) @(posedge ref_clk);
    @(posedge ref_clk);
    if (fail_next) st[op == 3'h1 ? 1 : 0] = 1'b1;
    rchk(fpe_pkg::ADDR_STAT, st);
  endtask
  task automatic irdc(input logic [15:0] e);
    @(posedge ref_clk);
    info_rd_req <= 1'b1;
    @(posedge ref_clk);
    info_rd_req <= 1'b0;
    #1 `CHK(arr_op, 3'h0)
    fin(3'h0);
    rchk(fpe_pkg::ADDR_INFO_DATA, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end
  // =====================================================
  // Tests
  initial begin
    {rst_n, reg_wr, reg_rd, fl_wr_req, fl_wr_debug, fl_wr_info} = '0;
    {reg_addr, reg_wdata, fl_wr_addr, fl_wr_data, info_rd_req} = '0;
    {info_location, fail_next, ctl, st, n_errors, checks_done} = '0;
    op_cycles = 4'h3;
    ra = '{fpe_pkg::ADDR_INFO_DATA, fpe_pkg::ADDR_LOW_WE,
           fpe_pkg::ADDR_HIGH_WE, fpe_pkg::ADDR_DATA_WE, fpe_pkg::ADDR_CTRL};
    void'($urandom(80));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rchk(ra[i], 16'h0000);
    rchk(fpe_pkg::ADDR_STAT, 16'h0000);
    rchk(24'hff_f948, 16'h0000);
    `CHK(arr_verify, 1'b1)
    $display("test reset done");
    foreach (ra[i]) begin
      rv = 16'($urandom);
      wr(ra[i], rv);
      rchk(ra[i], ra[i] == fpe_pkg::ADDR_CTRL ? rv & 16'h00fb : rv);
      wr(ra[i], 16'h0000);
    end
    // Reset in mid-run must clear every register again
    foreach (ra[i]) wr(ra[i], 16'hffff);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rchk(ra[i], 16'h0000);
    for (int v = 0; v < 4; v++) begin
      wctl({12'h000, v[1], 2'b00, v[0]});
      @(posedge ref_clk);
      #1 `CHK(arr_verify, ~v[1])
      `CHK(arr_low_power, v[0])
    end
    $display("test registers done");
    for (int s = 0; s < 3; s++) begin
      n = $urandom % 16;
      sz = s == 2 ? 512 : 8192;
      a = (s == 2 ? 'hd_0000 : s * 'h2_0000) + n * sz;
      a = a + ($urandom % (sz / 2)) * 2;
      wr(ra[s + 1], 16'h0001 << n);
      wctl(s == 1 ? 16'h0030 : 16'h0020);
      rv = 16'($urandom);
      req(24'(a), rv, 0, 0, 1, 3'h1, 24'(a));
      fin(3'h1);
      req(24'(a ^ sz), rv, 0, 0, 0, 3'h1, 24'h0);
      wr(ra[s + 1], 16'h0000);
    end
    $display("test sections done");
    wr(fpe_pkg::ADDR_LOW_WE, 16'hffff);
    wctl(16'h0040);
    fail_next = 1'b1;
    rv = 16'($urandom) & 16'hfffe;
    req({8'h00, rv}, rv, 0, 0, 1, 3'h2, {8'h00, rv & 16'hfc00});
    fin(3'h2);
    wctl(16'h0020);
    req({8'h01, rv}, rv, 0, 0, 1, 3'h1, {8'h01, rv});
    fin(3'h1);
    fail_next = 1'b0;
    wr(fpe_pkg::ADDR_STAT, 16'h0000);
    rchk(fpe_pkg::ADDR_STAT, st);
    wr(fpe_pkg::ADDR_STAT, 16'h0003);
    st = 16'h0000;
    rchk(fpe_pkg::ADDR_STAT, st);
    wctl(16'h0022);
    req({8'h01, rv}, rv, 0, 0, 0, 3'h1, {8'h01, rv});
    req({8'h01, rv}, rv, 0, 1, 1, 3'h1, {8'h01, rv});
    fin(3'h1);
    $display("test wipes and faults done");
    wctl(16'h0020);
    op_cycles = 4'hc;
    req({8'h01, rv}, rv, 0, 0, 1, 3'h1, {8'h01, rv});
    rchk(fpe_pkg::ADDR_STAT, 16'h0004);
    @(posedge ref_clk);
    fl_wr_req <= 1'b1;
    #1 `CHK(cpu_stall, 1'b1)
    @(posedge ref_clk);
    fl_wr_debug <= 1'b1;
    #1 `CHK(cpu_stall, 1'b0)
    @(posedge ref_clk);
    fl_wr_req <= 1'b0;
    st[fpe_pkg::ST_OVERRUN] = 1'b1;
    fin(3'h1);
    op_cycles = 4'h3;
    wr(fpe_pkg::ADDR_STAT, 16'h0010);
    st = 16'h0000;
    rchk(fpe_pkg::ADDR_STAT, st);
    $display("test busy done");
    rv = 16'($urandom);
    info_location <= 8'($urandom);
    wr(fpe_pkg::ADDR_INFO_DATA, rv);
    req(24'h0, rv, 1, 0, 1, 3'h1, {16'h0000, info_location & 8'hfe});
    fin(3'h1);
    wr(fpe_pkg::ADDR_INFO_DATA, 16'h0000);
    irdc(rv);
    wctl(16'h0040);
    req(24'h0, rv, 1, 0, 0, 3'h2, 24'h0);
    wctl(16'h0080);
    req(24'h0, rv, 1, 0, 1, 3'h3, 24'h0);
    fin(3'h3);
    irdc(16'hffff);
    $display("test info block done");
    give_verdict();
  end
endmodule
